// ---- src/mbfp_pkg.sv ----
// Shared constants, carriers and helpers.
package mbfp_pkg;
    // Sample width of every luma and chroma sample.
    localparam int SMP_W = 8;
    // Luma and chroma macroblock edge in samples.
    localparam int MB_LUMA = 16;
    localparam int MB_CHROMA = 8;
    // Only accepted chroma format code, for 4:2:0 material.
    localparam logic [1:0] FMT_420 = 2'h1;
    // FIFO depth and the slack kept ahead of it.
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_MARGIN = 3;
    // Delimiter pattern of the byte stream.
    localparam logic [31:0] SC_PATTERN = 32'h00000001;
    // Saturation bounds.
    localparam logic signed [17:0] RUN_MAX = 18'sh0003f;
    localparam logic signed [17:0] LEVEL_MAX = 18'sh007ff;
    localparam logic signed [17:0] MV_MAX = 18'sh01fff;
    localparam logic signed [17:0] MV_MIN = -18'sh02000;
    // Field chroma offset in quarter lines.
    localparam logic signed [1:0] VQ_TOP = -2'sh1;
    localparam logic signed [1:0] VQ_BOT = 2'sh1;
    localparam logic signed [1:0] VQ_NONE = 2'sh0;

    // Sample planes in the order the source delivers them.
    typedef enum logic [1:0] {MBFP_PL_Y, MBFP_PL_CB, MBFP_PL_CR} mbfp_plane_t;

    // Per-frame setup, latched at the start of each frame.
    typedef struct packed {
        logic [7:0] width_mb;
        logic [7:0] height_mb;
        logic interlaced;
        logic field_pic;
        logic bottom_sel;
        logic [1:0] chroma_fmt;
        logic [15:0] slice_len;
    } mbfp_cfg_t;

    // One tagged sample as it leaves the block.
    typedef struct packed {
        logic [SMP_W-1:0] sample;
        mbfp_plane_t plane;
        logic [7:0] mb_x;
        logic [7:0] mb_y;
        logic [3:0] col_in_mb;
        logic [1:0] blk8;
        logic field_bot;
        logic same_instant;
        logic signed [1:0] chroma_vq;
    } mbfp_tag_t;

    // One motion vector with both components.
    typedef struct packed {
        logic signed [15:0] h;
        logic signed [15:0] v;
    } mbfp_mv_t;

    // Clamps a value to the range from lo to hi.
    function automatic logic signed [17:0] mbfp_sat(input logic signed [17:0] v,
        input logic signed [17:0] lo, input logic signed [17:0] hi);
        mbfp_sat = (v > hi) ? hi : ((v < lo) ? lo : v);
    endfunction
endpackage

// ---- src/mbfp_fifo.sv ----
`timescale 1ns/1ns
// Sample FIFO with a registered head word.
module mbfp_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic in_valid_i,
    input wire logic [W-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [W-1:0] out_data_o,
    input wire logic out_ready_i,
    output logic [$clog2(D):0] level_o
);
    localparam int AW = $clog2(D);
    localparam logic [AW-1:0] LAST = AW'(D - 1);
    localparam logic [AW:0] FULL = (AW + 1)'(D);

    // Storage array and its pointers.
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    // Words in the array, the head register not counted.
    logic [AW:0] count;

    // A word moves to the head when the head is free or being drained.
    wire push = in_valid_i && in_ready_o;
    wire pop = (count != '0) && (!out_valid_o || out_ready_i);
    assign in_ready_o = count != FULL;
    assign level_o = count;

    // The array itself has no reset, only the pointers, count and head register.
    always_ff @(posedge ref_clk_i)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointers, count and head register.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            out_valid_o <= 1'b0;
            out_data_o <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
                out_data_o <= mem[rd_ptr];
                out_valid_o <= 1'b1;
            end
            else if (out_ready_i)
            begin
                out_valid_o <= 1'b0;
            end
            count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end

    // The writer never offers a word that the array cannot take.
    fifo_no_overrun_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        in_valid_i |-> in_ready_o) else $error("FIFO offered a word when full.");
endmodule

// ---- src/mbfp_runlev.sv ----
`timescale 1ns/1ns
// Turns a scan-ordered coefficient stream into saturated run and level pairs.
module mbfp_runlev (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic coef_valid_i,
    input wire logic signed [15:0] coef_i,
    input wire logic coef_last_i,
    output logic rl_valid_o,
    output logic [5:0] run_o,
    output logic [10:0] level_o,
    output logic sign_o
);
    // Zeros seen since the last non-zero coefficient or block end.
    logic [7:0] zeros;

    // Absolute value in a width that also holds the most negative input.
    wire logic signed [17:0] wide = 18'(coef_i);
    wire logic signed [17:0] mag = coef_i[15] ? -wide : wide;
    wire logic signed [17:0] run_sat = mbfp_pkg::mbfp_sat(18'(zeros), '0, mbfp_pkg::RUN_MAX);
    wire logic signed [17:0] lev_sat = mbfp_pkg::mbfp_sat(mag, '0, mbfp_pkg::LEVEL_MAX);
    wire nonzero = coef_valid_i && (coef_i != '0);

    // Counts zeros and emits one pair for each non-zero coefficient.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            zeros <= '0;
            rl_valid_o <= 1'b0;
            run_o <= '0;
            level_o <= '0;
            sign_o <= 1'b0;
        end
        else
        begin
            rl_valid_o <= nonzero; // R17
            if (nonzero)
            begin
                run_o <= run_sat[5:0]; // R16
                level_o <= lev_sat[10:0]; // R16
                sign_o <= coef_i[15];
            end
            // A block end or a non-zero value restarts the zero count.
            if (coef_valid_i && (coef_last_i || nonzero))
            begin
                zeros <= '0;
            end
            else if (coef_valid_i && zeros != 8'hff)
            begin
                zeros <= zeros + 8'h01;
            end
        end
    end

    run_count_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R17
        nonzero && zeros < 8'h3f |=> run_o == $past(zeros[5:0]))
        else $error("Run does not match the zero count.");
    level_clamp_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R16
        nonzero && mag > mbfp_pkg::LEVEL_MAX |=> level_o == 11'h7ff)
        else $error("Level not clamped to its maximum.");
endmodule

// ---- src/mbfp_top.sv ----
`timescale 1ns/1ns
// Contract
// R1: Source width and height are multiples of 16.
// R2: Only 4:2:0 chroma material is accepted.
// R3: Progressive and interlaced frames mix per frame.
// R4: Odd frame lines belong to top field.
// R5: Even frame lines belong to bottom field.
// R6: Field pictures keep only the selected field lines.
// R7: Progressive frames preferably coded as frame pictures.
// R8: Progressive frames still expose two same-instant fields.
// R9: Field chroma shifted quarter line up/down.
// R10: Horizontal chroma positions same in frame, field.
// R11: Pictures tile into 16x16 luma macroblocks.
// R12: Slices are runs of consecutive macroblocks.
// R13: Each slice decodes without other slices.
// R14: Motion vector horizontal component precedes vertical.
// R15: Luma 8x8 indices follow raster order 0-3.
// R16: Out-of-range values saturate to range bounds.
// R17: Run counts preceding zeros; level is magnitude.
// R18: Skipped macroblocks advance without taking payload.
// R19: 32-bit start codes are recognised as delimiters.
// R20: Stuffing bytes are discarded from the stream.
// R21: Samples are 8 bits in three planes.
// R22: Macroblock coding order is raster order.
// R23: Synchronous reset clears all counters.
module mbfp_top (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic frame_start_i,
    input wire mbfp_pkg::mbfp_cfg_t cfg_i,
    output logic fmt_err_o,
    input wire logic smp_valid_i,
    input wire logic [mbfp_pkg::SMP_W-1:0] smp_i,
    output logic smp_ready_o,
    output logic frame_done_o,
    output logic out_valid_o,
    output mbfp_pkg::mbfp_tag_t out_o,
    input wire logic out_ready_i,
    input wire logic mb_done_i,
    input wire logic mb_skip_i,
    output logic [7:0] mb_x_o,
    output logic [7:0] mb_y_o,
    output logic [15:0] slice_id_o,
    output logic slice_first_o,
    output logic payload_take_o,
    output logic pic_end_o,
    input wire logic mv_valid_i,
    input wire mbfp_pkg::mbfp_mv_t mv_i,
    output logic mv_ready_o,
    output logic mv_comp_valid_o,
    output logic signed [15:0] mv_comp_o,
    output logic mv_is_vert_o,
    input wire logic byte_valid_i,
    input wire logic [7:0] byte_i,
    input wire logic stuff_i,
    output logic byte_valid_o,
    output logic [7:0] byte_o,
    output logic start_code_o,
    input wire logic coef_valid_i,
    input wire logic signed [15:0] coef_i,
    input wire logic coef_last_i,
    output logic rl_valid_o,
    output logic [5:0] run_o,
    output logic [10:0] level_o,
    output logic sign_o
);
    localparam int TW = $bits(mbfp_pkg::mbfp_tag_t);
    localparam int LW = $clog2(mbfp_pkg::FIFO_DEPTH) + 1;
    localparam logic [LW-1:0] READY_LVL = LW'(mbfp_pkg::FIFO_DEPTH - mbfp_pkg::FIFO_MARGIN);
    // Setup of the frame in progress.
    mbfp_pkg::mbfp_cfg_t cfg;
    // Raster position of the next sample.
    logic [11:0] col;
    logic [11:0] row;
    mbfp_pkg::mbfp_plane_t plane;
    // Tagging stage in front of the FIFO.
    logic tag_valid;
    mbfp_pkg::mbfp_tag_t tag;
    logic [LW-1:0] fifo_level;
    logic [TW-1:0] fifo_out;
    // Plane size in samples; chroma is half both ways.
    wire is_luma = plane == mbfp_pkg::MBFP_PL_Y;
    wire [11:0] plane_w = is_luma ? {cfg.width_mb, 4'h0} : {1'b0, cfg.width_mb, 3'h0};
    wire [11:0] plane_h = is_luma ? {cfg.height_mb, 4'h0} : {1'b0, cfg.height_mb, 3'h0};
    wire last_col = col == plane_w - 12'h001;
    wire last_row = row == plane_h - 12'h001;
    wire accept = smp_valid_i && smp_ready_o;
    // Row zero is line one, so an odd row index is a bottom-field line.
    wire line_bot = row[0]; // R4 R5
    wire keep = !fmt_err_o && (!cfg.field_pic || line_bot == cfg.bottom_sel); // R2 R6
    wire [11:0] pic_row = cfg.field_pic ? {1'b0, row[11:1]} : row;
    // Macroblock coordinates and in-block column of the sample.
    wire [7:0] tag_mb_x = is_luma ? col[11:4] : col[10:3]; // R11
    wire [7:0] tag_mb_y = is_luma ? pic_row[11:4] : pic_row[10:3]; // R11
    wire [3:0] tag_col = is_luma ? col[3:0] : {1'b0, col[2:0]}; // R10
    wire [1:0] tag_blk = is_luma ? {pic_row[3], col[3]} : 2'h0; // R15
    wire chroma_field = cfg.field_pic && !is_luma;
    wire logic signed [1:0] tag_vq = !chroma_field ? mbfp_pkg::VQ_NONE :
        (cfg.bottom_sel ? mbfp_pkg::VQ_BOT : mbfp_pkg::VQ_TOP); // R9
    wire frame_end = accept && last_col && last_row && plane == mbfp_pkg::MBFP_PL_CR;
    // Latches the setup per frame, so each frame may change scan type.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            cfg <= '0;
            fmt_err_o <= 1'b0;
        end
        else if (frame_start_i)
        begin
            cfg <= cfg_i; // R3
            fmt_err_o <= cfg_i.chroma_fmt != mbfp_pkg::FMT_420; // R2
        end
    end
    // Walks columns, rows and planes of the source raster.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i || frame_start_i)
        begin
            col <= '0; // R23
            row <= '0; // R23
            plane <= mbfp_pkg::MBFP_PL_Y;
        end
        else if (accept)
        begin
            col <= last_col ? 12'h000 : col + 12'h001;
            if (last_col)
            begin
                row <= last_row ? 12'h000 : row + 12'h001;
            end
            if (last_col && last_row)
            begin
                case (plane)
                    mbfp_pkg::MBFP_PL_Y: plane <= mbfp_pkg::MBFP_PL_CB;
                    mbfp_pkg::MBFP_PL_CB: plane <= mbfp_pkg::MBFP_PL_CR;
                    default: plane <= mbfp_pkg::MBFP_PL_Y;
                endcase
            end
        end
    end
    // Tags kept samples; lines of the other field are dropped here.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            tag_valid <= 1'b0;
            tag <= '0;
            smp_ready_o <= 1'b0;
            frame_done_o <= 1'b0;
        end
        else
        begin
            tag_valid <= accept && keep; // R6
            if (accept)
            begin
                tag <= '{smp_i, plane, tag_mb_x, tag_mb_y, tag_col, tag_blk,
                    line_bot, !cfg.interlaced, tag_vq}; // R8 R21
            end
            // Slack covers the sample in flight and the level lag.
            smp_ready_o <= fifo_level < READY_LVL;
            frame_done_o <= frame_end;
        end
    end
    // Buffer between the tagging stage and the coding datapath.
    mbfp_fifo #(
        .W(TW),
        .D(mbfp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(tag_valid),
        .in_data_i(tag),
        .in_ready_o(),
        .out_valid_o(out_valid_o),
        .out_data_o(fifo_out),
        .out_ready_i(out_ready_i),
        .level_o(fifo_level)
    );
    assign out_o = mbfp_pkg::mbfp_tag_t'(fifo_out);
    // Coding-order sequencer: raster macroblocks grouped into slices.
    logic [15:0] slice_cnt;
    wire last_mb_x = mb_x_o == cfg.width_mb - 8'h01;
    wire last_mb_y = mb_y_o == cfg.height_mb - 8'h01;
    wire slice_full = slice_cnt + 16'h0001 == cfg.slice_len;
    // Advances one macroblock per completion.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i || frame_start_i)
        begin
            mb_x_o <= '0; // R23
            mb_y_o <= '0; // R23
            slice_cnt <= '0; // R23
            slice_id_o <= '0; // R23
            slice_first_o <= 1'b1;
            payload_take_o <= 1'b0;
            pic_end_o <= 1'b0;
        end
        else
        begin
            payload_take_o <= mb_done_i && !mb_skip_i; // R18
            pic_end_o <= mb_done_i && last_mb_x && last_mb_y;
            if (mb_done_i)
            begin
                mb_x_o <= last_mb_x ? 8'h00 : mb_x_o + 8'h01; // R22
                if (last_mb_x)
                begin
                    mb_y_o <= last_mb_y ? 8'h00 : mb_y_o + 8'h01; // R22
                end
                // A new slice is flagged on slice_first_o for the datapath.
                slice_cnt <= slice_full ? 16'h0000 : slice_cnt + 16'h0001; // R12
                slice_id_o <= slice_full ? slice_id_o + 16'h0001 : slice_id_o;
                slice_first_o <= slice_full; // R13
            end
        end
    end
    // Motion vector serialiser states.
    typedef enum logic {MBFP_MV_IDLE, MBFP_MV_VERT} mbfp_mv_st_t;
    mbfp_mv_st_t mv_st;
    logic signed [15:0] mv_vert;
    wire mv_take = mv_valid_i && mv_ready_o;
    wire logic signed [17:0] mv_h_sat = mbfp_pkg::mbfp_sat(18'(mv_i.h), mbfp_pkg::MV_MIN,
        mbfp_pkg::MV_MAX);
    wire logic signed [17:0] mv_v_sat = mbfp_pkg::mbfp_sat(18'(mv_i.v), mbfp_pkg::MV_MIN,
        mbfp_pkg::MV_MAX);
    // Sends the horizontal component, then the vertical one.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            mv_st <= MBFP_MV_IDLE;
            mv_vert <= '0;
            mv_ready_o <= 1'b0;
            mv_comp_valid_o <= 1'b0;
            mv_comp_o <= '0;
            mv_is_vert_o <= 1'b0;
        end
        else
        begin
            mv_ready_o <= !(mv_st == MBFP_MV_IDLE && mv_take);
            case (mv_st)
                MBFP_MV_IDLE:
                begin
                    mv_comp_valid_o <= mv_take;
                    mv_is_vert_o <= 1'b0;
                    if (mv_take)
                    begin
                        mv_comp_o <= mv_h_sat[15:0]; // R14 R16
                        mv_vert <= mv_v_sat[15:0]; // R16
                        mv_st <= MBFP_MV_VERT;
                    end
                end
                default:
                begin
                    mv_comp_valid_o <= 1'b1;
                    mv_comp_o <= mv_vert; // R14
                    mv_is_vert_o <= 1'b1;
                    mv_st <= MBFP_MV_IDLE;
                end
            endcase
        end
    end
    // Last three payload bytes, for delimiter search.
    logic [23:0] hist;
    wire byte_keep = byte_valid_i && !stuff_i; // R20
    // Forwards bytes and flags delimiters.
    always_ff @(posedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            hist <= 24'hffffff;
            byte_valid_o <= 1'b0;
            byte_o <= '0;
            start_code_o <= 1'b0;
        end
        else
        begin
            byte_valid_o <= byte_keep; // R20
            start_code_o <= byte_keep && {hist, byte_i} == mbfp_pkg::SC_PATTERN; // R19
            if (byte_keep)
            begin
                hist <= {hist[15:0], byte_i};
                byte_o <= byte_i;
            end
        end
    end
    // Run and level conversion of the residual coefficients.
    mbfp_runlev u_runlev (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .coef_valid_i(coef_valid_i),
        .coef_i(coef_i),
        .coef_last_i(coef_last_i),
        .rl_valid_o(rl_valid_o),
        .run_o(run_o),
        .level_o(level_o),
        .sign_o(sign_o)
    );
    // Two-step vector output.
    sequence mv_h_s;
        mv_take ##1 mv_comp_valid_o && !mv_is_vert_o;
    endsequence
    sequence mv_v_s;
        mv_comp_valid_o && mv_is_vert_o;
    endsequence
    field_drop_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R6
        accept && cfg.field_pic && line_bot != cfg.bottom_sel |=> !tag_valid)
        else $error("Line of the other field was kept.");
    field_parity_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R4
        accept && keep |=> tag_valid && tag.field_bot == $past(row[0]))
        else $error("Field parity of a line is wrong.");
    chroma_phase_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R9
        accept && keep && chroma_field && !cfg.bottom_sel |=> tag.chroma_vq == -2'sh1)
        else $error("Top field chroma not shifted up.");
    blk_order_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R15
        accept && is_luma && !pic_row[3] && col[3] |=> tag.blk8 == 2'h1)
        else $error("Luma 8x8 index not in raster order.");
    fmt_reject_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R2
        fmt_err_o |=> !tag_valid) else $error("Sample of a bad format was kept.");
    mv_order_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R14
        mv_h_s |=> mv_v_s) else $error("Vertical component did not follow.");
    skip_payload_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R18
        mb_done_i && mb_skip_i |=> !payload_take_o) else $error("Skipped MB took payload.");
    slice_run_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R12
        mb_done_i && !frame_start_i && !last_mb_x |=> mb_x_o == $past(mb_x_o) + 8'h01)
        else $error("Macroblock order skipped a position.");
    start_code_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R19
        byte_keep && hist == 24'h000000 && byte_i == 8'h01 |=> start_code_o)
        else $error("Delimiter pattern missed.");
    stuff_drop_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // R20
        byte_valid_i && stuff_i |=> !byte_valid_o && $stable(hist))
        else $error("Stuffing byte was passed on.");
    reset_clear_a: assert property (@(posedge ref_clk_i) // R23
        !rstn_i |=> col == '0 && row == '0 && slice_cnt == '0)
        else $error("Counters not cleared by reset.");
endmodule

// ---- sim/mbfp_sink.sv ----
`timescale 1ns/1ns
// Datapath stand-in: stalls at first, then at random.
module mbfp_sink (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    output logic out_ready_o
);
    // Cycles since reset.
    logic [7:0] cnt;
    // Stall pattern.
    logic [15:0] pat;

    // Ready moves on the falling edge.
    always @(negedge ref_clk_i)
    begin
        if (!rstn_i)
        begin
            cnt <= 8'h00;
            pat <= 16'h00b5;
            out_ready_o <= 1'b0;
        end
        else
        begin
            pat <= {pat[14:0], pat[15] ^ pat[13] ^ pat[12] ^ pat[10]};
            cnt <= (cnt == 8'hff) ? cnt : cnt + 8'h01;
            out_ready_o <= (cnt > 8'h3c) && (pat[1:0] != 2'h0);
        end
    end
endmodule

// ---- sim/mbfp_top_bench.sv ----
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin mismatches++; \
$display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
// Drivers queue expectations; a monitor checks outputs.
module mbfp_top_bench;
    // Block inputs.
    logic ref_clk_i = 0, rstn_i = 0, frame_start_i = 0, smp_valid_i = 0, out_ready_i;
    logic mb_done_i = 0, mb_skip_i = 0, mv_valid_i = 0, byte_valid_i = 0, stuff_i = 0;
    logic coef_valid_i = 0, coef_last_i = 0;
    logic [7:0] smp_i = 8'h00, byte_i = 8'h00;
    logic signed [15:0] coef_i = 16'sh0000;
    mbfp_pkg::mbfp_cfg_t cfg_i = '0;
    mbfp_pkg::mbfp_mv_t mv_i = '0;
    // Block outputs.
    logic fmt_err_o, smp_ready_o, frame_done_o, out_valid_o, slice_first_o, payload_take_o;
    logic pic_end_o, mv_ready_o, mv_comp_valid_o, mv_is_vert_o, byte_valid_o, start_code_o;
    logic rl_valid_o, sign_o;
    logic [7:0] mb_x_o, mb_y_o, byte_o;
    logic [15:0] slice_id_o;
    logic signed [15:0] mv_comp_o;
    logic [5:0] run_o;
    logic [10:0] level_o;
    mbfp_pkg::mbfp_tag_t out_o, et;
    // Counters, state and queues.
    int mismatches = 0, cmp_count = 0, cyc = 0, zc = 0;
    logic [31:0] lfsr = 32'h006e;
    logic [23:0] hist = 24'h0;
    logic [17:0] e;
    mbfp_pkg::mbfp_tag_t tag_q[$];
    logic [17:0] mv_q[$], byte_q[$], rl_q[$];
    // Coded bytes, stuffing flag on top.
    logic [8:0] bseq[14] = '{9'h000, 9'h000, 9'h1ff, 9'h000, 9'h001, 9'h012, 9'h000,
        9'h000, 9'h001, 9'h000, 9'h000, 9'h000, 9'h000, 9'h001};

    mbfp_top u_mbfp_top (.*);
    mbfp_sink u_mbfp_sink (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .out_ready_o(out_ready_i));

    // Clock of 100 ns.
    initial
    begin
        forever #50 ref_clk_i = ~ref_clk_i;
    end

    // Steps the random source.
    function automatic logic [31:0] step(input logic [31:0] s);
        step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Prints counts and verdict, then ends.
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Starts a frame and checks the format flag.
    task automatic start(input mbfp_pkg::mbfp_cfg_t c);
        cfg_i = c;
        frame_start_i = 1;
        @(negedge ref_clk_i);
        frame_start_i = 0;
        repeat (2) @(negedge ref_clk_i);
        `CHK("fmt_err", (c.chroma_fmt != mbfp_pkg::FMT_420), fmt_err_o)
    endtask

    // Sends a one-macroblock frame, noting each kept sample.
    task automatic frame(input logic il, input logic fp, input logic bs, input logic [1:0] fm);
        mbfp_pkg::mbfp_tag_t t;
        logic [3:0] pr;
        start('{8'h01, 8'h01, il, fp, bs, fm, 16'h0000});
        for (int p = 0; p < 3; p++)
            for (int r = 0; r < ((p == 0) ? 16 : 8); r++)
                for (int c = 0; c < ((p == 0) ? 16 : 8); c++)
                begin
                    lfsr = step(lfsr);
                    pr = fp ? 4'(r >> 1) : 4'(r);
                    t = '{lfsr[7:0], mbfp_pkg::mbfp_plane_t'(p), 8'h00, 8'h00, 4'(c),
                        (p == 0) ? {pr[3], c[3]} : 2'h0, r[0], !il,
                        (fp && p != 0) ? (bs ? mbfp_pkg::VQ_BOT : mbfp_pkg::VQ_TOP)
                        : mbfp_pkg::VQ_NONE};
                    smp_valid_i = 1;
                    smp_i = lfsr[7:0];
                    while (smp_ready_o !== 1'b1)
                        @(negedge ref_clk_i);
                    if (fm == mbfp_pkg::FMT_420 && (!fp || r[0] == bs))
                        tag_q.push_back(t);
                    @(negedge ref_clk_i);
                end
        smp_valid_i = 0;
        `CHK("frame_done", 1'b1, frame_done_o)
    endtask

    // Offers one vector.
    task automatic put_mv(input logic [15:0] h, v, eh, ev);
        mv_valid_i = 1;
        mv_i = '{h, v};
        while (mv_ready_o !== 1'b1)
            @(negedge ref_clk_i);
        mv_q.push_back({1'b0, eh});
        mv_q.push_back({1'b1, ev});
        @(negedge ref_clk_i);
    endtask

    // Sends one coefficient.
    task automatic put_coef(input logic signed [15:0] v, input logic last);
        int a;
        a = (v < 0) ? -int'(v) : int'(v);
        coef_valid_i = 1;
        coef_i = v;
        coef_last_i = last;
        if (v != 0)
            rl_q.push_back({(zc > 63) ? 6'h3f : 6'(zc), v < 0, (a > 2047) ? 11'h7ff : 11'(a)});
        zc = (v != 0 || last) ? 0 : zc + 1;
        @(negedge ref_clk_i);
    endtask

    // Monitor: each output takes the oldest note.
    always @(posedge ref_clk_i)
    begin
        if (out_valid_o && out_ready_i)
        begin
            et = tag_q.pop_front();
            `CHK("tag", et, out_o)
        end
        if (mv_comp_valid_o)
        begin
            e = mv_q.pop_front();
            `CHK("mv", e, {mv_is_vert_o, mv_comp_o})
        end
        if (byte_valid_o)
        begin
            e = byte_q.pop_front();
            `CHK("byte", e, {start_code_o, byte_o})
        end
        if (rl_valid_o)
        begin
            e = rl_q.pop_front();
            `CHK("runlev", e, {run_o, sign_o, level_o})
        end
        cyc++;
        if (cyc == 30000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    // Main sequence.
    initial
    begin
        repeat (6) @(negedge ref_clk_i);
        rstn_i = 1;
        @(negedge ref_clk_i);
        `CHK("slice_first", 1'b1, slice_first_o)
        frame(0, 0, 0, mbfp_pkg::FMT_420);
        frame(1, 1, 1, mbfp_pkg::FMT_420);
        frame(1, 1, 0, mbfp_pkg::FMT_420);
        frame(1, 0, 0, mbfp_pkg::FMT_420);
        frame(0, 0, 0, 2'h2);
        start('{8'h03, 8'h02, 1'b0, 1'b0, 1'b0, mbfp_pkg::FMT_420, 16'h0002});
        mb_done_i = 1;
        for (int k = 1; k <= 6; k++)
        begin
            lfsr = step(lfsr);
            mb_skip_i = lfsr[0];
            @(negedge ref_clk_i);
            if (k < 6)
            begin
                `CHK("mb_x", 8'(k % 3), mb_x_o)
                `CHK("mb_y", 8'(k / 3), mb_y_o)
            end
            `CHK("slice_first", (k % 2 == 0), slice_first_o)
            `CHK("slice_id", 16'(k / 2), slice_id_o)
            `CHK("payload", !mb_skip_i, payload_take_o)
            `CHK("pic_end", (k == 6), pic_end_o)
        end
        mb_done_i = 0;
        put_mv(16'h7fff, 16'h9000, 16'h1fff, 16'he000);
        put_mv(16'hfff5, 16'h0007, 16'hfff5, 16'h0007);
        mv_valid_i = 0;
        for (int i = 0; i < 14; i++)
        begin
            byte_valid_i = 1;
            {stuff_i, byte_i} = bseq[i];
            if (!stuff_i)
            begin
                byte_q.push_back({hist == 24'h0 && byte_i == 8'h01, byte_i});
                hist = {hist[15:0], byte_i};
            end
            @(negedge ref_clk_i);
        end
        byte_valid_i = 0;
        put_coef(0, 0);
        put_coef(0, 0);
        put_coef(5, 0);
        put_coef(-3, 0);
        repeat (70) put_coef(0, 0);
        put_coef(3000, 0);
        put_coef(0, 1);
        put_coef(-16'sh8000, 0);
        repeat (20)
        begin
            lfsr = step(lfsr);
            put_coef(lfsr[1:0] == 2'h0 ? lfsr[17:2] : 16'sh0000, lfsr[20]);
        end
        coef_valid_i = 0;
        repeat (60) @(negedge ref_clk_i);
        `CHK("left", 0, tag_q.size() + mv_q.size() + byte_q.size() + rl_q.size())
        tally_and_finish();
    end
endmodule
